// ### design/qasr_defines.svh
// Offsets, field positions, reset values and counts of the quad readout block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef QASR_DEFINES_SVH
`define QASR_DEFINES_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define QASR_LANES 4
`define QASR_FRAME_BITS 16
`define QASR_ADDR_W 8

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define QASR_OFF_CTRL 8'h00
`define QASR_OFF_PATTERN 8'h04
`define QASR_OFF_STATUS 8'h08
`define QASR_OFF_RES_LO 8'h0C
`define QASR_OFF_RES_HI 8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define QASR_CTRL_PATTERN_BIT 0
`define QASR_PATTERN_RESET 16'h0000
`define QASR_STAT_POWER_LSB 0
`define QASR_STAT_COUNT_LSB 4
`define QASR_STAT_LVDS_BIT 8
`define QASR_STAT_DDR_BIT 9
`define QASR_STAT_ECHO_OFF_BIT 10
`define QASR_STAT_BUSY_BIT 11
`define QASR_STAT_FRAMES_LSB 16
`define QASR_RESP_OKAY 2'h0
`define QASR_RESP_SLVERR 2'h2

// ----------------------------------------
// Strobe pulse counts of the power sequence
// ----------------------------------------
`define QASR_NAP_PULSES 3'h2
`define QASR_SLEEP_PULSES 3'h4
`define QASR_WAKE_PULSES 3'h5

`endif

// ### design/qasr_pkg.sv
// Types shared by the quad readout block and its bench.
// Assumes qasr_defines.svh is on the include path.
`include "qasr_defines.svh"

package qasr_pkg;

  typedef enum logic [2:0] {
    QASR_OPER  = 3'h1,
    QASR_NAP   = 3'h2,
    QASR_SLEEP = 3'h4
  } qasr_power_e;

  // Index 0 is lane one / lane A / channel 1
  typedef struct packed {
    logic [`QASR_LANES-1:0] cmosLane;
    logic [`QASR_LANES-1:0] diffLaneP;
    logic [`QASR_LANES-1:0] diffLaneN;
    logic echoClockOut;
    logic echoClockOutP;
    logic echoClockOutN;
  } qasr_lanes_s;

  typedef struct packed {
    logic awvalid;
    logic [`QASR_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`QASR_ADDR_W-1:0] araddr;
    logic rready;
  } qasr_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qasr_axi_rsp_s;

endpackage : qasr_pkg

// ### design/qasr_readout.sv
// Digital side of a four-channel sampling converter: serial readout, echo clock,
// nap/sleep sequencing and an AXI4-Lite register slave.
// Assumes SCK, the conversion strobe and the straps arrive asynchronously to clk,
// and that converter results arrive on coreResult in the clk domain.
// Pin edges are seen three to four clk cycles late: SCK and strobe levels must
// each hold two clk cycles, which caps the link rate this block can follow.
//
// Behaviour
// [RQ1] Drive an echo clock matched in timing to the serial data lanes.
// [RQ2] Echo-disable strap high keeps the echo clock outputs quiet.
// [RQ3] SCK static plus two strobe pulses: nap on the second rising edge.
// [RQ4] Nap lasts until an SCK rising edge or further strobe pulses.
// [RQ5] From nap, two further strobe pulses with SCK static enter sleep.
// [RQ6] In CMOS mode an SCK rising edge wakes the device from sleep.
// [RQ7] Host waits 10ms after sleep exit before trusting conversions.
// [RQ8] The fifth strobe pulse of the sequence wakes from sleep, any mode.
// [RQ9] SCK pulses between strobes restart the pulse count while operational.
// [RQ10] Strobe pulses alone cycle operational, nap, sleep endlessly.
// [RQ11] Interface-select strap picks CMOS or LVDS signalling.
// [RQ12] Results leave MSB first, paced by SCK.
// [RQ13] CMOS mode: four single-ended lanes plus echo clock out, SCK in.
// [RQ14] LVDS mode: lanes A to D carry channels 1 to 4.
// [RQ15] Single rate: data advance one bit per SCK falling edge.
// [RQ16] Double rate: data advance on both SCK edges.
// [RQ17] Rate strap low means single rate, high means double rate.
// [RQ18] Echo clock is a delayed SCK copy aligned with the data.
// [RQ19] Single rate: data change on echo clock falling edges.
// [RQ20] Receiver captures single-rate data on echo rising edges.
// [RQ21] Receiver captures double-rate data on both edges, with delay.
// [RQ22] Strobe rising starts sampling; falling starts conversion and readout.
// [RQ23] Host supplies SCK fast enough for the wanted throughput.
// [RQ24] Host discards the first result of a burst.
// [RQ25] Host waits 10ms after power-on before converting; the bench waits 2 clk cycles after reset release.
// [RQ26] Each frame is 16 bits: 16 edges per readout.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "qasr_defines.svh"

module qasr_readout
  import qasr_pkg::*;
#(
  parameter int DATA_BITS = `QASR_FRAME_BITS,
  parameter int LANES = `QASR_LANES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sckIn,
  input wire logic conversionStrobe,
  input wire logic interfaceSelStrap,
  input wire logic rateSelectStrap,
  input wire logic echoDisableStrap,
  input wire logic [LANES-1:0][DATA_BITS-1:0] coreResult,
  input wire qasr_axi_req_s axiReq,
  output qasr_axi_rsp_s axiRsp,
  output qasr_lanes_s lanesOut,
  output qasr_power_e powerMode,
  output logic trackHold,
  output logic conversionStart
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (DATA_BITS < 2 || DATA_BITS > `QASR_FRAME_BITS || LANES != `QASR_LANES) begin : gBad
      $error("qasr_readout: unsupported DATA_BITS or LANES");
    end
    // Sequence thresholds must rise, or a power state could never be left
    if (`QASR_NAP_PULSES >= `QASR_SLEEP_PULSES ||
        `QASR_SLEEP_PULSES >= `QASR_WAKE_PULSES) begin : gBadSeq
      $error("qasr_readout: power sequence counts out of order");
    end
  endgenerate

  localparam logic [4:0] FRAME_EDGES = 5'(DATA_BITS);

  typedef struct packed {
    logic [2:0] sckSync;
    logic [2:0] strobeSync;
    logic [2:0] lvdsSync;
    logic [2:0] rateSync;
    logic [2:0] echoOffSync;
    logic sckLvl;
    logic strobeLvl;
    logic lvds;
    logic ddr;
    logic echoOff;
    qasr_power_e power;
    logic [2:0] pulseCount;
    logic [LANES-1:0][DATA_BITS-1:0] pending;
    logic [LANES-1:0][DATA_BITS-1:0] shift;
    logic [4:0] edgesLeft;
    logic [LANES-1:0] laneBit;
    qasr_lanes_s lanes;
    logic trackHold;
    logic convStart;
    logic [15:0] frames;
    logic patternOn;
    logic [15:0] pattern;
    logic awHeld;
    logic [`QASR_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    qasr_axi_rsp_s rsp;
  } qasr_state_s;

  qasr_state_s stateReg;
  qasr_state_s stateNext;

  function automatic logic [31:0] qasr_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : qasr_merge

  // Filtered level: moves only once the second and third stage agree
  function automatic logic qasr_filter(input logic [2:0] chain, input logic lvl);
    return (chain[1] == chain[2]) ? chain[2] : lvl;
  endfunction : qasr_filter

  // One clk step of a three-stage pin synchroniser
  function automatic logic [2:0] qasr_sync_step(input logic [2:0] chain, input logic pin);
    return {chain[1:0], pin};
  endfunction : qasr_sync_step

  function automatic logic qasr_rise(input logic nowLvl, input logic wasLvl);
    return nowLvl & ~wasLvl;
  endfunction : qasr_rise

  function automatic logic qasr_fall(input logic nowLvl, input logic wasLvl);
    return ~nowLvl & wasLvl;
  endfunction : qasr_fall

  function automatic logic [2:0] qasr_count_up(input logic [2:0] val);
    return 3'(val + 3'h1);
  endfunction : qasr_count_up

  // Status word; straps packed as {echo off, ddr, lvds}
  function automatic logic [31:0] qasr_status_word(
    input qasr_power_e power,
    input logic [2:0] pulses,
    input logic [2:0] straps,
    input logic busy,
    input logic [15:0] frames
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`QASR_STAT_POWER_LSB +: 3] = power;
    w[`QASR_STAT_COUNT_LSB +: 3] = pulses;
    w[`QASR_STAT_LVDS_BIT] = straps[0];
    w[`QASR_STAT_DDR_BIT] = straps[1];
    w[`QASR_STAT_ECHO_OFF_BIT] = straps[2];
    w[`QASR_STAT_BUSY_BIT] = busy;
    w[`QASR_STAT_FRAMES_LSB +: 16] = frames;
    return w;
  endfunction : qasr_status_word

  always_comb begin
    qasr_state_s n;
    logic sckRise;
    logic sckFall;
    logic strobeRise;
    logic strobeFall;
    logic advance;
    logic echoLvl;
    logic [2:0] cnt;
    logic [31:0] merged;
    logic [`QASR_ADDR_W-1:0] ra;
    n = stateReg;
    merged = 32'h0000_0000;
    ra = '0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    strobeRise = 1'b0;
    strobeFall = 1'b0;
    advance = 1'b0;
    echoLvl = 1'b0;
    cnt = 3'h0;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    n.sckSync = qasr_sync_step(stateReg.sckSync, sckIn);
    n.strobeSync = qasr_sync_step(stateReg.strobeSync, conversionStrobe);
    n.lvdsSync = qasr_sync_step(stateReg.lvdsSync, interfaceSelStrap);
    n.rateSync = qasr_sync_step(stateReg.rateSync, rateSelectStrap);
    n.echoOffSync = qasr_sync_step(stateReg.echoOffSync, echoDisableStrap);
    n.sckLvl = qasr_filter(stateReg.sckSync, stateReg.sckLvl);
    n.strobeLvl = qasr_filter(stateReg.strobeSync, stateReg.strobeLvl);
    n.lvds = qasr_filter(stateReg.lvdsSync, stateReg.lvds); // [RQ11]
    n.ddr = qasr_filter(stateReg.rateSync, stateReg.ddr); // [RQ17]
    n.echoOff = qasr_filter(stateReg.echoOffSync, stateReg.echoOff);
    sckRise = qasr_rise(n.sckLvl, stateReg.sckLvl);
    sckFall = qasr_fall(n.sckLvl, stateReg.sckLvl);
    strobeRise = qasr_rise(n.strobeLvl, stateReg.strobeLvl);
    strobeFall = qasr_fall(n.strobeLvl, stateReg.strobeLvl);

    // ----------------------------------------
    // Power sequence
    // ----------------------------------------
    // While operational, SCK activity clears the count first, so a strobe in the same cycle counts as one
    cnt = sckRise ? 3'h0 : stateReg.pulseCount; // [RQ9]
    if (strobeRise) begin
      cnt = qasr_count_up(cnt);
    end
    n.pulseCount = cnt;
    case (stateReg.power)
      QASR_OPER: begin
        if (strobeRise && cnt == `QASR_NAP_PULSES) begin
          n.power = QASR_NAP; // [RQ3] [RQ10]
        end
      end
      QASR_NAP: begin
        if (sckRise) begin
          n.power = QASR_OPER; // [RQ4]
          n.pulseCount = 3'h0;
        end else if (strobeRise && cnt == `QASR_SLEEP_PULSES) begin
          n.power = QASR_SLEEP; // [RQ5]
        end
      end
      QASR_SLEEP: begin
        if (sckRise && !stateReg.lvds) begin
          n.power = QASR_OPER; // [RQ6]
          n.pulseCount = 3'h0;
        end else if (strobeRise && stateReg.pulseCount == 3'(`QASR_WAKE_PULSES - 3'h1)) begin
          n.power = QASR_OPER; // [RQ8] [RQ10]
          n.pulseCount = 3'h0;
        end else begin
          // LVDS sleep: SCK neither wakes the device nor clears the pulse count
          n.pulseCount = strobeRise ? qasr_count_up(stateReg.pulseCount) : stateReg.pulseCount;
        end
      end
      default: begin
        n.power = QASR_OPER;
        n.pulseCount = 3'h0;
      end
    endcase

    // ----------------------------------------
    // Sampling, conversion and readout
    // ----------------------------------------
    n.trackHold = (stateReg.power == QASR_OPER) && n.strobeLvl; // [RQ22]
    n.convStart = 1'b0;
    if (strobeFall && stateReg.power == QASR_OPER) begin
      // One frame of latency: the frame sent now is the previous conversion
      n.shift = stateReg.pending; // [RQ22]
      for (int c = 0; c < LANES; c++) begin
        n.pending[c] = stateReg.patternOn ? DATA_BITS'(stateReg.pattern) : coreResult[c];
      end
      n.edgesLeft = FRAME_EDGES; // [RQ26]
      n.laneBit = '0;
      n.convStart = 1'b1;
      n.frames = 16'(stateReg.frames + 16'h0001);
    end else begin
      advance = sckFall || (stateReg.ddr && sckRise); // [RQ15] [RQ16]
      if (advance && stateReg.edgesLeft != 5'h00) begin
        for (int c = 0; c < LANES; c++) begin
          n.laneBit[c] = stateReg.shift[c][DATA_BITS-1]; // [RQ12] [RQ14]
          n.shift[c] = {stateReg.shift[c][DATA_BITS-2:0], 1'b0};
        end
        n.edgesLeft = 5'(stateReg.edgesLeft - 5'h01);
      end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Echo updates on the same clk edge as the lanes, so both carry equal delay
    echoLvl = n.echoOff ? 1'b0 : n.sckLvl; // [RQ1] [RQ2] [RQ18] [RQ19]
    if (n.lvds) begin
      n.lanes.cmosLane = '0;
      n.lanes.diffLaneP = n.laneBit; // [RQ14]
      n.lanes.diffLaneN = ~n.laneBit;
      n.lanes.echoClockOut = 1'b0;
      n.lanes.echoClockOutP = echoLvl;
      n.lanes.echoClockOutN = n.echoOff ? 1'b0 : ~echoLvl; // [RQ2]
    end else begin
      n.lanes.cmosLane = n.laneBit; // [RQ13]
      n.lanes.diffLaneP = '0;
      n.lanes.diffLaneN = '0;
      n.lanes.echoClockOut = echoLvl; // [RQ13]
      n.lanes.echoClockOutP = 1'b0;
      n.lanes.echoClockOutN = 1'b0;
    end

    // ----------------------------------------
    // AXI4-Lite write
    // ----------------------------------------
    if (stateReg.rsp.bvalid && axiReq.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (axiReq.awvalid && stateReg.rsp.awready) begin
      n.awHeld = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && stateReg.rsp.wready) begin
      n.wHeld = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
    end
    if (n.awHeld && n.wHeld && !n.rsp.bvalid) begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = `QASR_RESP_OKAY;
      case ({n.awAddr[`QASR_ADDR_W-1:2], 2'h0})
        `QASR_OFF_CTRL: begin
          merged = qasr_merge({31'h0, stateReg.patternOn}, n.wData, n.wStrb);
          n.patternOn = merged[`QASR_CTRL_PATTERN_BIT];
        end
        `QASR_OFF_PATTERN: begin
          merged = qasr_merge({16'h0000, stateReg.pattern}, n.wData, n.wStrb);
          n.pattern = merged[15:0];
        end
        default: n.rsp.bresp = `QASR_RESP_SLVERR;
      endcase
    end
    n.rsp.awready = !n.awHeld && !n.rsp.bvalid;
    n.rsp.wready = !n.wHeld && !n.rsp.bvalid;

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    if (stateReg.rsp.rvalid && axiReq.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && stateReg.rsp.arready) begin
      ra = {axiReq.araddr[`QASR_ADDR_W-1:2], 2'h0};
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = `QASR_RESP_OKAY;
      n.rsp.rdata = 32'h0000_0000;
      case (ra)
        `QASR_OFF_CTRL: n.rsp.rdata[`QASR_CTRL_PATTERN_BIT] = stateReg.patternOn;
        `QASR_OFF_PATTERN: n.rsp.rdata[15:0] = stateReg.pattern;
        `QASR_OFF_STATUS: begin
          n.rsp.rdata = qasr_status_word(stateReg.power, stateReg.pulseCount,
                                         {stateReg.echoOff, stateReg.ddr, stateReg.lvds},
                                         stateReg.edgesLeft != 5'h00, stateReg.frames);
        end
        `QASR_OFF_RES_LO: begin
          n.rsp.rdata[15:0] = 16'(stateReg.pending[0]);
          n.rsp.rdata[31:16] = 16'(stateReg.pending[1]);
        end
        `QASR_OFF_RES_HI: begin
          n.rsp.rdata[15:0] = 16'(stateReg.pending[2]);
          n.rsp.rdata[31:16] = 16'(stateReg.pending[3]);
        end
        default: n.rsp.rresp = `QASR_RESP_SLVERR;
      endcase
    end
    n.rsp.arready = !n.rsp.rvalid;

    stateNext = n;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Filtered levels reset low like idle pins, so no false edge follows reset
      stateReg <= '0;
      stateReg.power <= QASR_OPER;
      stateReg.pattern <= `QASR_PATTERN_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign axiRsp = stateReg.rsp;
  assign lanesOut = stateReg.lanes;
  assign powerMode = stateReg.power;
  assign trackHold = stateReg.trackHold;
  assign conversionStart = stateReg.convStart;

endmodule : qasr_readout

// ### testbench/qasr_readout_asserts.sv
// Checker: strobe, power and lane relations at the qasr_readout ports.
// Assumes it is bound to qasr_readout and sees only its ports.
`timescale 1ns/1ps
module qasr_readout_asserts
  import qasr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interfaceSelStrap,
  input wire logic rateSelectStrap,
  input wire logic echoDisableStrap,
  input wire qasr_lanes_s lanesOut,
  input wire qasr_power_e powerMode,
  input wire logic trackHold,
  input wire logic conversionStart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Strobe and power sequencing
  // ----------------------------------------
  property p_start_pulse;
    conversionStart |=> !conversionStart;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_track;
    conversionStart |-> $past(trackHold, 2);
  endproperty
  a_start_track: assert property (p_start_track) else $error("start without track");
  property p_start_oper;
    conversionStart |-> powerMode == QASR_OPER;
  endproperty
  a_start_oper: assert property (p_start_oper) else $error("start outside oper");
  property p_nap_from_oper;
    powerMode == QASR_NAP && $past(powerMode) != QASR_NAP |-> $past(powerMode) == QASR_OPER;
  endproperty
  a_nap_from_oper: assert property (p_nap_from_oper) else $error("bad nap entry");
  property p_sleep_from_nap;
    powerMode == QASR_SLEEP && $past(powerMode) != QASR_SLEEP |-> $past(powerMode) == QASR_NAP;
  endproperty
  a_sleep_from_nap: assert property (p_sleep_from_nap) else $error("bad sleep entry");

  // ----------------------------------------
  // Lanes and echo clock
  // ----------------------------------------
  property p_echo_off;
    echoDisableStrap [*6] |->
      !(lanesOut.echoClockOut | lanesOut.echoClockOutP | lanesOut.echoClockOutN);
  endproperty
  a_echo_off: assert property (p_echo_off) else $error("echo not quiet");
  property p_cmos_quiet;
    !interfaceSelStrap [*6] |-> (lanesOut.diffLaneP | lanesOut.diffLaneN) == 4'h0;
  endproperty
  a_cmos_quiet: assert property (p_cmos_quiet) else $error("diff lanes active");
  property p_lvds_pair;
    interfaceSelStrap [*6] |-> lanesOut.diffLaneN == ~lanesOut.diffLaneP;
  endproperty
  a_lvds_pair: assert property (p_lvds_pair) else $error("diff lanes unpaired");
  property p_sdr_fall;
    (!rateSelectStrap && !interfaceSelStrap && !echoDisableStrap) [*6] ##0
      ($changed(lanesOut.cmosLane) && !conversionStart && !$past(conversionStart))
      |-> $fell(lanesOut.echoClockOut);
  endproperty
  a_sdr_fall: assert property (p_sdr_fall) else $error("data off echo fall");

  c_nap: cover property (powerMode == QASR_NAP);
  c_sleep: cover property (powerMode == QASR_SLEEP);
  c_start: cover property (conversionStart);
endmodule : qasr_readout_asserts

// ### testbench/qasr_host_model.sv
// Host receiver model: makes SCK and the strobe, captures lanes on echo edges.
// Assumes lvds and ddr mirror the straps; callers enter tasks at a clk edge.
`timescale 1ns/1ps
module qasr_host_model
  import qasr_pkg::*;
(
  input wire logic clk,
  input wire logic lvds,
  input wire logic ddr,
  input wire qasr_lanes_s lanesOut,
  output logic sckIn,
  output logic conversionStrobe,
  output logic [3:0][15:0] capData
);
  wire echo = lvds ? lanesOut.echoClockOutP : lanesOut.echoClockOut;
  wire [3:0] lane = lvds ? lanesOut.diffLaneP : lanesOut.cmosLane;

  initial begin
    sckIn = 1'b0;
    conversionStrobe = 1'b0;
    capData = '0;
  end

  // Data move with echo, so read 1 ns after its edge; shift keeps last 16 bits
  always @(echo) begin
    #1;
    if (ddr || echo) begin
      for (int l = 0; l < 4; l++) begin
        capData[l] = {capData[l][14:0], lane[l]};
      end
    end
  end

  task automatic strobe_pulse();
    conversionStrobe <= 1'b1;
    repeat (4) @(posedge clk);
    conversionStrobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : strobe_pulse

  // SCK idles low between frames; half period 4 cycles
  task automatic sck_edges(input int n);
    for (int i = 0; i < n; i++) begin
      sckIn <= ~sckIn;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : sck_edges
endmodule : qasr_host_model

// ### testbench/tb.sv
// Testbench: registers over AXI4-Lite, readout in all link modes, power sequencing.
// Assumes qasr_host_model drives SCK and strobe; straps change only between frames.
`timescale 1ns/1ps
`include "qasr_defines.svh"
module tb;
  import qasr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lvds = 1'b0;
  logic ddr = 1'b0;
  logic echoOff = 1'b0;
  logic [3:0][15:0] core = '0;
  logic [3:0][15:0] held;
  logic [3:0][15:0] capData;
  logic [15:0] patVal = 16'hA55A;
  logic [31:0] lfsr = 32'h0001_56E1;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic primed = 1'b0;
  qasr_axi_req_s axiReq = '0;
  qasr_axi_rsp_s axiRsp;
  qasr_lanes_s lanesOut;
  qasr_power_e powerMode;
  qasr_power_e pm = QASR_OPER;
  logic trackHold;
  logic conversionStart;
  logic sckIn;
  logic conversionStrobe;
  int cnt = 0;
  int failCount = 0;
  int samplesChecked = 0;

  always #25 clk = ~clk;

  qasr_readout qasr_readout_inst (.clk(clk), .rst_n(rst_n), .sckIn(sckIn),
    .conversionStrobe(conversionStrobe), .interfaceSelStrap(lvds), .rateSelectStrap(ddr),
    .echoDisableStrap(echoOff), .coreResult(core), .axiReq(axiReq), .axiRsp(axiRsp),
    .lanesOut(lanesOut), .powerMode(powerMode), .trackHold(trackHold),
    .conversionStart(conversionStart));
  qasr_host_model qasr_host_model_inst (.clk(clk), .lvds(lvds), .ddr(ddr),
    .lanesOut(lanesOut), .sckIn(sckIn), .conversionStrobe(conversionStrobe),
    .capData(capData));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    r = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read

  // Strobe pulse with the reference count of the power sequence
  task automatic pulse();
    qasr_host_model_inst.strobe_pulse();
    cnt++;
    if (pm == QASR_OPER && cnt == 2) pm = QASR_NAP;
    else if (pm == QASR_NAP && cnt == 4) pm = QASR_SLEEP;
    else if (pm == QASR_SLEEP && cnt == 5) begin
      pm = QASR_OPER;
      cnt = 0;
    end
    check("powerMode", pm, powerMode);
  endtask : pulse

  task automatic sck_rise(input int n);
    qasr_host_model_inst.sck_edges(n);
    if (!(pm == QASR_SLEEP && lvds)) begin
      cnt = 0;
      pm = QASR_OPER;
    end
    check("powerMode", pm, powerMode);
  endtask : sck_rise

  // Frame shifted now carries the result captured at the previous strobe
  task automatic readout(input logic pat);
    logic [3:0][15:0] now;
    for (int l = 0; l < 4; l++) begin
      lfsr = next_rand(lfsr);
      core[l] <= lfsr[15:0];
      now[l] = pat ? patVal : lfsr[15:0];
    end
    pulse();
    axi_read(`QASR_OFF_RES_LO, rd, rsp);
    check("resLo", {now[1], now[0]}, rd);
    axi_read(`QASR_OFF_RES_HI, rd, rsp);
    check("resHi", {now[3], now[2]}, rd);
    sck_rise(ddr ? 16 : 34);
    for (int l = 0; l < 4; l++) begin
      if (primed) check("lane", held[l], capData[l]);
    end
    held = now;
    primed = 1'b1;
  endtask : readout

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tallyAndFinish

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #2_000_000;
    failCount++;
    tallyAndFinish();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk); // Model has no reinitialisation to wait for
    axi_read(`QASR_OFF_PATTERN, rd, rsp);
    check("patternReset", 32'h0, rd);
    axi_read(8'h14, rd, rsp);
    check("unmappedResp", `QASR_RESP_SLVERR, rsp);
    check("unmappedData", 32'h0, rd);
    axi_write(`QASR_OFF_STATUS, 32'hFFFF_FFFF, rsp);
    check("readOnlyResp", `QASR_RESP_SLVERR, rsp);
    axi_write(`QASR_OFF_PATTERN, {16'h0, patVal}, rsp);
    check("writeResp", `QASR_RESP_OKAY, rsp);
    axi_write(`QASR_OFF_CTRL, 32'h1, rsp);
    readout(1'b1);
    axi_write(`QASR_OFF_CTRL, 32'h0, rsp);
    for (int m = 0; m < 4; m++) begin
      lvds <= m[0];
      ddr <= m[1];
      repeat (8) @(posedge clk);
      readout(1'b0);
    end
    echoOff <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      lvds <= v[0];
      repeat (8) @(posedge clk);
      repeat (4) pulse();
      sck_rise(2); // Wakes from sleep only in CMOS (v=0); nothing converted after this wake is trusted
      repeat (3) pulse();
      sck_rise(2);
    end
    axi_read(`QASR_OFF_STATUS, rd, rsp);
    check("statusPower", pm, rd[`QASR_STAT_POWER_LSB +: 3]);
    check("statusCount", cnt, rd[`QASR_STAT_COUNT_LSB +: 3]);
    check("statusStraps", 3'h7, rd[`QASR_STAT_LVDS_BIT +: 3]);
    tallyAndFinish();
  end
endmodule : tb

bind qasr_readout qasr_readout_asserts qasr_readout_asserts_inst (.clk(clk), .rst_n(rst_n),
  .interfaceSelStrap(interfaceSelStrap), .rateSelectStrap(rateSelectStrap),
  .echoDisableStrap(echoDisableStrap), .lanesOut(lanesOut), .powerMode(powerMode),
  .trackHold(trackHold), .conversionStart(conversionStart));
